/* File: common/hdm_pkg.sv */
package hdm_pkg;
  localparam int          HDM_DATA_W     = 32;
  localparam int          HDM_ADDR_W     = 8;
  localparam int          HDM_IDX_W      = 6;
  localparam int          HDM_WORDS      = 63;
  localparam int          HDM_VALID_BIT  = 15;
  localparam int          HDM_LEN_MSB    = 7;
  localparam int          HDM_LEN_W      = 8;
  localparam int          HDM_IACK_LSB   = 3;
  localparam int          HDM_IACK_W     = 5;
  localparam int          HDM_IRQEN_BIT  = 0;
  localparam logic [5:0]  HDM_FINAL_IDX  = 6'h3F;
  localparam logic [1:0]  HDM_REG_H2D    = 2'h0;
  localparam logic [1:0]  HDM_REG_D2H    = 2'h1;
  localparam logic [7:0]  HDM_TEST_ADDR  = 8'h80;
  localparam logic [7:0]  HDM_FIFO_ADDR  = 8'h81;
  localparam logic [7:0]  HDM_IRQEN_ADDR = 8'h82;
  localparam logic [31:0] HDM_WORD_RST   = 32'h0;
  localparam logic [31:0] HDM_UNMAPPED   = 32'h0;
  localparam logic [7:0]  HDM_LEN_RST    = 8'h0;
endpackage

/* File: verilog/hdm_mbox.sv */
`timescale 1ns/100ps
module hdm_mbox #(
  parameter int WORDS = hdm_pkg::HDM_WORDS
) (
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic        a_we,
  input  wire logic [5:0]  a_idx,
  input  wire logic [31:0] a_wdata,
  input  wire logic        b_we,
  input  wire logic [5:0]  b_idx,
  input  wire logic [31:0] b_wdata,
  output logic      [31:0] a_rdata,
  output logic      [31:0] b_rdata,
  output logic             pending,
  output logic      [7:0]  byte_count,
  output logic             msg_event
);
  logic [31:0] mem [0:WORDS-1];
  logic        pending_r;
  logic [7:0]  count_r;
  logic        a_fin;
  logic        b_fin;
  logic [31:0] final_word;

  assign a_fin = a_we && (a_idx == hdm_pkg::HDM_FINAL_IDX);
  assign b_fin = b_we && (b_idx == hdm_pkg::HDM_FINAL_IDX);

  // Data words storage
  // Sender port wins on a same-word collision
  always_ff @(posedge mclk) begin
    if (srst) begin
      for (int i = 0; i < WORDS; i++) begin
        mem[i] <= hdm_pkg::HDM_WORD_RST;
      end
    end else begin
      if (b_we && !b_fin && !(a_we && a_idx == b_idx)) begin
        mem[b_idx] <= b_wdata;
      end
      if (a_we && !a_fin) begin
        mem[a_idx] <= a_wdata;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      pending_r <= 1'b0;
      count_r   <= hdm_pkg::HDM_LEN_RST;
    end else if (a_fin) begin
      pending_r <= a_wdata[hdm_pkg::HDM_VALID_BIT];
      count_r   <= a_wdata[hdm_pkg::HDM_LEN_MSB:0];
    end else if (b_fin) begin
      pending_r <= b_wdata[hdm_pkg::HDM_VALID_BIT];
      count_r   <= b_wdata[hdm_pkg::HDM_LEN_MSB:0];
    end
  end

  always_comb begin
    final_word = hdm_pkg::HDM_WORD_RST;
    final_word[hdm_pkg::HDM_VALID_BIT] = pending_r;
    final_word[hdm_pkg::HDM_LEN_MSB:0] = count_r;
  end

  assign a_rdata = (a_idx == hdm_pkg::HDM_FINAL_IDX) ? final_word
                                                     : mem[a_idx];
  assign b_rdata = (b_idx == hdm_pkg::HDM_FINAL_IDX) ? final_word
                                                     : mem[b_idx];

  assign msg_event  = a_fin && a_wdata[hdm_pkg::HDM_VALID_BIT];
  assign pending    = pending_r;
  assign byte_count = count_r;
endmodule

/* File: verilog/hdm_mailbox.sv */
`timescale 1ns/100ps
// Contract
// - Each direction: 63 data words plus final
// - Final word write completes the message
// - Data words read back last written value
// - Host valid write interrupts the DSP
// - DSP valid write interrupts the host
// - Host interrupt needs mailbox enable set
// - Interrupt acknowledge returns length upper bits
// - Data port pushes out, pops in
// - Scratch register stores and returns value
module hdm_mailbox (
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic [7:0]  host_addr,
  input  wire logic        host_wr,
  input  wire logic        host_rd,
  input  wire logic [31:0] host_wdata,
  output logic      [31:0] host_rdata_r,
  output logic             host_rvalid_r,
  input  wire logic        host_iack,
  output logic      [4:0]  host_iack_status_r,
  output logic             host_iack_valid_r,
  output logic             host_irq_r,
  input  wire logic [7:0]  dsp_addr,
  input  wire logic        dsp_wr,
  input  wire logic        dsp_rd,
  input  wire logic [31:0] dsp_wdata,
  output logic      [31:0] dsp_rdata_r,
  output logic             dsp_rvalid_r,
  output logic             dsp_irq_r,
  output logic      [31:0] tx_data_r,
  output logic             tx_valid_r,
  input  wire logic        tx_ready,
  input  wire logic [31:0] rx_data,
  input  wire logic        rx_valid,
  output logic             rx_pop_r
);
  logic        h_h2d;
  logic        h_d2h;
  logic        d_h2d;
  logic        d_d2h;
  logic [31:0] h2d_host_q;
  logic [31:0] h2d_dsp_q;
  logic [31:0] d2h_host_q;
  logic [31:0] d2h_dsp_q;
  logic        h2d_pending;
  logic        d2h_pending;
  logic [7:0]  h2d_count;
  logic [7:0]  d2h_count;
  logic        h2d_evt;
  logic        d2h_evt;
  logic [31:0] test_r;
  logic        irq_en_r;
  logic        h_fifo_wr;
  logic        d_fifo_wr;
  logic        fifo_push;
  logic        h_fifo_rd;
  logic        d_fifo_rd;

  assign h_h2d = host_addr[7:6] == hdm_pkg::HDM_REG_H2D;
  assign h_d2h = host_addr[7:6] == hdm_pkg::HDM_REG_D2H;
  assign d_h2d = dsp_addr[7:6] == hdm_pkg::HDM_REG_H2D;
  assign d_d2h = dsp_addr[7:6] == hdm_pkg::HDM_REG_D2H;

  // Host is sender of this mailbox
  // DSP reply and flag clear on port b
  hdm_mbox #(
    .WORDS (hdm_pkg::HDM_WORDS)
  ) u_h2d (
    .mclk       (mclk),
    .srst       (srst),
    .a_we       (host_wr && h_h2d),
    .a_idx      (host_addr[5:0]),
    .a_wdata    (host_wdata),
    .b_we       (dsp_wr && d_h2d),
    .b_idx      (dsp_addr[5:0]),
    .b_wdata    (dsp_wdata),
    .a_rdata    (h2d_host_q),
    .b_rdata    (h2d_dsp_q),
    .pending    (h2d_pending),
    .byte_count (h2d_count),
    .msg_event  (h2d_evt)
  );

  // DSP is sender of this mailbox
  // Host reply and flag clear on port b
  hdm_mbox #(
    .WORDS (hdm_pkg::HDM_WORDS)
  ) u_d2h (
    .mclk       (mclk),
    .srst       (srst),
    .a_we       (dsp_wr && d_d2h),
    .a_idx      (dsp_addr[5:0]),
    .a_wdata    (dsp_wdata),
    .b_we       (host_wr && h_d2h),
    .b_idx      (host_addr[5:0]),
    .b_wdata    (host_wdata),
    .a_rdata    (d2h_dsp_q),
    .b_rdata    (d2h_host_q),
    .pending    (d2h_pending),
    .byte_count (d2h_count),
    .msg_event  (d2h_evt)
  );

  // Special words: host write wins a same-cycle clash
  // Scratch word
  always_ff @(posedge mclk) begin
    if (srst) begin
      test_r <= hdm_pkg::HDM_WORD_RST;
    end else if (host_wr && host_addr == hdm_pkg::HDM_TEST_ADDR) begin
      test_r <= host_wdata;
    end else if (dsp_wr && dsp_addr == hdm_pkg::HDM_TEST_ADDR) begin
      test_r <= dsp_wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      irq_en_r <= 1'b0;
    end else if (host_wr && host_addr == hdm_pkg::HDM_IRQEN_ADDR) begin
      irq_en_r <= host_wdata[hdm_pkg::HDM_IRQEN_BIT];
    end else if (dsp_wr && dsp_addr == hdm_pkg::HDM_IRQEN_ADDR) begin
      irq_en_r <= dsp_wdata[hdm_pkg::HDM_IRQEN_BIT];
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      dsp_irq_r <= 1'b0;
    end else begin
      dsp_irq_r <= h2d_evt;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      host_irq_r <= 1'b0;
    end else begin
      host_irq_r <= d2h_evt && irq_en_r;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      host_iack_valid_r  <= 1'b0;
      host_iack_status_r <= '0;
    end else begin
      host_iack_valid_r <= host_iack;
      if (host_iack) begin
        host_iack_status_r <= d2h_count[hdm_pkg::HDM_LEN_MSB:
                                        hdm_pkg::HDM_IACK_LSB];
      end
    end
  end

  assign h_fifo_wr = host_wr && host_addr == hdm_pkg::HDM_FIFO_ADDR;
  assign d_fifo_wr = dsp_wr && dsp_addr == hdm_pkg::HDM_FIFO_ADDR;
  assign fifo_push = (h_fifo_wr || d_fifo_wr) && (!tx_valid_r || tx_ready);
  assign h_fifo_rd = host_rd && host_addr == hdm_pkg::HDM_FIFO_ADDR;
  assign d_fifo_rd = dsp_rd && dsp_addr == hdm_pkg::HDM_FIFO_ADDR;

  // Push to outgoing link
  // A word written while the slot is full and tx_ready is low is dropped
  always_ff @(posedge mclk) begin
    if (srst) begin
      tx_valid_r <= 1'b0;
      tx_data_r  <= hdm_pkg::HDM_WORD_RST;
    end else if (fifo_push) begin
      tx_valid_r <= 1'b1;
      tx_data_r  <= h_fifo_wr ? host_wdata : dsp_wdata;
    end else if (tx_ready) begin
      tx_valid_r <= 1'b0;
    end
  end

  // Pop from incoming link
  // Pop is a flop, so reads must be two cycles apart
  always_ff @(posedge mclk) begin
    if (srst) begin
      rx_pop_r <= 1'b0;
    end else begin
      rx_pop_r <= (h_fifo_rd || d_fifo_rd) && rx_valid && !rx_pop_r;
    end
  end

  function automatic logic [31:0] rd_mux(
    input logic [7:0]  addr,
    input logic [31:0] h2d_q,
    input logic [31:0] d2h_q
  );
    logic [31:0] v;
    v = hdm_pkg::HDM_UNMAPPED;
    if (addr[7:6] == hdm_pkg::HDM_REG_H2D) begin
      v = h2d_q;
    end else if (addr[7:6] == hdm_pkg::HDM_REG_D2H) begin
      v = d2h_q;
    end else if (addr == hdm_pkg::HDM_TEST_ADDR) begin
      v = test_r;
    end else if (addr == hdm_pkg::HDM_FIFO_ADDR) begin
      v = rx_data;
    end else if (addr == hdm_pkg::HDM_IRQEN_ADDR) begin
      v[hdm_pkg::HDM_IRQEN_BIT] = irq_en_r;
    end
    return v;
  endfunction

  always_ff @(posedge mclk) begin
    if (srst) begin
      host_rvalid_r <= 1'b0;
      host_rdata_r  <= hdm_pkg::HDM_WORD_RST;
    end else begin
      host_rvalid_r <= host_rd;
      if (host_rd) begin
        host_rdata_r <= rd_mux(host_addr, h2d_host_q, d2h_host_q);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      dsp_rvalid_r <= 1'b0;
      dsp_rdata_r  <= hdm_pkg::HDM_WORD_RST;
    end else begin
      dsp_rvalid_r <= dsp_rd;
      if (dsp_rd) begin
        dsp_rdata_r <= rd_mux(dsp_addr, h2d_dsp_q, d2h_dsp_q);
      end
    end
  end
endmodule

/* File: testbench/hdm_mailbox_properties.sv */
`timescale 1ns/100ps
module hdm_mailbox_chk (
  input wire logic        mclk,
  input wire logic        srst,
  input wire logic [7:0]  host_addr,
  input wire logic        host_wr,
  input wire logic        host_rd,
  input wire logic [31:0] host_wdata,
  input wire logic [31:0] host_rdata_r,
  input wire logic        host_rvalid_r,
  input wire logic        host_iack,
  input wire logic        host_iack_valid_r,
  input wire logic        host_irq_r,
  input wire logic [7:0]  dsp_addr,
  input wire logic        dsp_wr,
  input wire logic        dsp_rd,
  input wire logic [31:0] dsp_wdata,
  input wire logic        dsp_rvalid_r,
  input wire logic        dsp_irq_r,
  input wire logic [31:0] tx_data_r,
  input wire logic        tx_valid_r,
  input wire logic        tx_ready,
  input wire logic [31:0] rx_data,
  input wire logic        rx_valid,
  input wire logic        rx_pop_r
);
  logic h2d_go_r;
  logic d2h_go_r;
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  sequence h2d_go;
    host_wr && host_addr == 8'h3F && host_wdata[15];
  endsequence
  sequence link_rd;
    host_rd && host_addr == 8'h81 && rx_valid && !rx_pop_r;
  endsequence
  // Final-word writes seen one cycle late
  always_ff @(posedge mclk) begin
    h2d_go_r <= !srst && host_wr && host_addr == 8'h3F && host_wdata[15];
    d2h_go_r <= !srst && dsp_wr && dsp_addr == 8'h7F && dsp_wdata[15];
  end
  AST_HOST_RD: assert property (host_rd |=> host_rvalid_r)
    else $error("host read not answered");
  AST_DSP_RD: assert property (dsp_rd |=> dsp_rvalid_r)
    else $error("dsp read not answered");
  AST_DSP_IRQ: assert property (h2d_go |=> dsp_irq_r)
    else $error("dsp interrupt missing");
  AST_DSP_IRQ_CAUSE: assert property (dsp_irq_r |-> h2d_go_r)
    else $error("dsp interrupt without cause");
  AST_HOST_IRQ_CAUSE: assert property (host_irq_r |-> d2h_go_r)
    else $error("host interrupt without cause");
  AST_IACK: assert property (host_iack |=> host_iack_valid_r)
    else $error("acknowledge status missing");
  AST_TX_HOLD: assert property (tx_valid_r && !tx_ready
    |=> tx_valid_r && $stable(tx_data_r))
    else $error("outgoing word lost");
  AST_RX_POP: assert property (link_rd
    |=> rx_pop_r && host_rdata_r == $past(rx_data))
    else $error("incoming word not popped");
  AST_NO_SPUR_POP: assert property (rx_pop_r |-> $past(rx_valid))
    else $error("pop of empty fifo");
endmodule
bind hdm_mailbox hdm_mailbox_chk hdm_mailbox_chk_i (
  .mclk              (mclk),
  .srst              (srst),
  .host_addr         (host_addr),
  .host_wr           (host_wr),
  .host_rd           (host_rd),
  .host_wdata        (host_wdata),
  .host_rdata_r      (host_rdata_r),
  .host_rvalid_r     (host_rvalid_r),
  .host_iack         (host_iack),
  .host_iack_valid_r (host_iack_valid_r),
  .host_irq_r        (host_irq_r),
  .dsp_addr          (dsp_addr),
  .dsp_wr            (dsp_wr),
  .dsp_rd            (dsp_rd),
  .dsp_wdata         (dsp_wdata),
  .dsp_rvalid_r      (dsp_rvalid_r),
  .dsp_irq_r         (dsp_irq_r),
  .tx_data_r         (tx_data_r),
  .tx_valid_r        (tx_valid_r),
  .tx_ready          (tx_ready),
  .rx_data           (rx_data),
  .rx_valid          (rx_valid),
  .rx_pop_r          (rx_pop_r)
);

/* File: testbench/hdm_link_model.sv */
`timescale 1ns/100ps
module hdm_link_model (
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic        stall,
  output logic             tx_ready,
  output logic      [31:0] rx_data,
  output logic             rx_valid,
  input  wire logic        rx_pop_r
);
  logic [3:0] cnt_r;
  assign tx_ready = !stall;
  // Empty source shows a fixed inverse pattern, not stale data
  assign rx_valid = cnt_r < 4'h4;
  assign rx_data = rx_valid ? {28'hA500000, cnt_r} : ~{28'hA500000, cnt_r};
  always_ff @(posedge mclk) begin
    if (srst) cnt_r <= 4'h0;
    else if (rx_pop_r) cnt_r <= cnt_r + 4'h1;
  end
endmodule

/* File: testbench/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  logic        mclk = 1'h0;
  logic        srst = 1'h1;
  logic        host_wr = 1'h0, host_rd = 1'h0, host_iack = 1'h0;
  logic        dsp_wr = 1'h0, dsp_rd = 1'h0, stall = 1'h0;
  logic [7:0]  host_addr = 8'h00, dsp_addr = 8'h00;
  logic [31:0] host_wdata = 32'h0, dsp_wdata = 32'h0;
  logic [31:0] host_rdata_r, dsp_rdata_r, tx_data_r, rx_data;
  logic [4:0]  host_iack_status_r;
  logic        host_rvalid_r, dsp_rvalid_r, host_iack_valid_r, host_irq_r;
  logic        dsp_irq_r, tx_valid_r, tx_ready, rx_valid, rx_pop_r;
  logic [31:0] hq[$], dq[$], tq[$], msg[5];
  logic [31:0] seed = 32'h67343854;
  logic [31:0] v;
  int          n_errors = 0, compares = 0, n_hirq = 0, n_dirq = 0, n_iack = 0;

  hdm_mailbox hdm_mailbox_i (
    .mclk               (mclk),
    .srst               (srst),
    .host_addr          (host_addr),
    .host_wr            (host_wr),
    .host_rd            (host_rd),
    .host_wdata         (host_wdata),
    .host_rdata_r       (host_rdata_r),
    .host_rvalid_r      (host_rvalid_r),
    .host_iack          (host_iack),
    .host_iack_status_r (host_iack_status_r),
    .host_iack_valid_r  (host_iack_valid_r),
    .host_irq_r         (host_irq_r),
    .dsp_addr           (dsp_addr),
    .dsp_wr             (dsp_wr),
    .dsp_rd             (dsp_rd),
    .dsp_wdata          (dsp_wdata),
    .dsp_rdata_r        (dsp_rdata_r),
    .dsp_rvalid_r       (dsp_rvalid_r),
    .dsp_irq_r          (dsp_irq_r),
    .tx_data_r          (tx_data_r),
    .tx_valid_r         (tx_valid_r),
    .tx_ready           (tx_ready),
    .rx_data            (rx_data),
    .rx_valid           (rx_valid),
    .rx_pop_r           (rx_pop_r)
  );
  hdm_link_model hdm_link_model_i (
    .mclk     (mclk),
    .srst     (srst),
    .stall    (stall),
    .tx_ready (tx_ready),
    .rx_data  (rx_data),
    .rx_valid (rx_valid),
    .rx_pop_r (rx_pop_r)
  );

  always #10 mclk = ~mclk;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Op 1 writes x, op 2 reads and expects x, op 0 idles
  task automatic acc(input logic d, input logic [1:0] op,
                     input logic [7:0] a, input logic [31:0] x);
    @(posedge mclk);
    #1;
    host_wr = !d && op == 2'h1;
    host_rd = !d && op == 2'h2;
    dsp_wr = d && op == 2'h1;
    dsp_rd = d && op == 2'h2;
    host_addr = a;
    dsp_addr = a;
    host_wdata = x;
    dsp_wdata = x;
    if (op == 2'h2 && d) dq.push_back(x);
    if (op == 2'h2 && !d) hq.push_back(x);
  endtask

  task automatic final_report();
    $display("compares=%0d errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  always @(posedge mclk) begin
    if (host_rvalid_r === 1'h1) chk(host_rdata_r, hq.pop_front());
    if (dsp_rvalid_r === 1'h1) chk(dsp_rdata_r, dq.pop_front());
    if (tx_valid_r === 1'h1 && tx_ready === 1'h1) begin
      chk(tx_data_r, tq.pop_front());
    end
    if (host_iack_valid_r === 1'h1) begin
      n_iack++;
      chk(host_iack_status_r, 5'h1F);
    end
    if (host_irq_r === 1'h1) n_hirq++;
    if (dsp_irq_r === 1'h1) n_dirq++;
  end

  initial begin
    #100us;
    n_errors++;
    final_report();
  end

  initial begin
    repeat (5) @(posedge mclk);
    #1 srst = 1'h0;
    acc(0, 2'h2, 8'h3E, 32'h0);
    acc(1, 2'h2, 8'h7F, 32'h0);
    acc(0, 2'h2, 8'hC5, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      msg[i] = rnd();
      acc(0, 2'h1, 8'h3A + 8'(i), msg[i]);
    end
    acc(0, 2'h1, 8'h3F, 32'h00008014);
    for (int i = 0; i < 5; i++) acc(1, 2'h2, 8'h3A + 8'(i), msg[i]);
    acc(1, 2'h2, 8'h3F, 32'h00008014);
    acc(1, 2'h1, 8'h3F, 32'h00000004);
    acc(0, 2'h2, 8'h3F, 32'h00000004);
    // Let a stray pulse from the reply write reach the monitor
    acc(0, 2'h0, 8'h00, 32'h0);
    chk(n_dirq, 1);
    $display("test host message done");
    v = rnd();
    acc(0, 2'h1, 8'h80, v);
    acc(1, 2'h2, 8'h80, v);
    acc(1, 2'h1, 8'h7F, 32'h00008008);
    repeat (2) acc(0, 2'h0, 8'h00, 32'h0);
    chk(n_hirq, 0);
    acc(0, 2'h1, 8'h82, 32'h1);
    acc(0, 2'h2, 8'h82, 32'h1);
    acc(1, 2'h1, 8'h7F, 32'h000080F8);
    // Acknowledge only once the new length has landed
    acc(0, 2'h0, 8'h00, 32'h0);
    host_iack = 1'h1;
    acc(0, 2'h0, 8'h00, 32'h0);
    host_iack = 1'h0;
    acc(0, 2'h1, 8'h7F, 32'h000000F8);
    acc(1, 2'h2, 8'h7F, 32'h000000F8);
    chk(n_hirq, 1);
    chk(n_iack, 1);
    $display("test dsp message done");
    stall = 1'h1;
    v = rnd();
    tq.push_back(v);
    acc(0, 2'h1, 8'h81, v);
    acc(0, 2'h1, 8'h81, rnd());
    repeat (3) acc(0, 2'h0, 8'h00, 32'h0);
    stall = 1'h0;
    acc(0, 2'h2, 8'h81, 32'hA5000000);
    repeat (2) acc(0, 2'h0, 8'h00, 32'h0);
    acc(1, 2'h2, 8'h81, 32'hA5000001);
    repeat (3) acc(0, 2'h0, 8'h00, 32'h0);
    chk(hq.size() + dq.size() + tq.size(), 0);
    $display("test link port done");
    final_report();
  end
endmodule
